// [hw/smrb_pkg.sv]
// Package with register map, field positions and reset values of the bank.
package smrb_pkg;
    // Register addresses.
    localparam logic [7:0] ADDR_SUPPLY_OUTPUT_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_MONITOR_CONFIGURATION = 8'h02;
    localparam logic [7:0] ADDR_SUPPLY_THERMAL_STATUS = 8'h03;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h06;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h07;
    // Reset values.
    localparam logic [7:0] RST_SUPPLY_OUTPUT_CONTROL = 8'h74;
    localparam logic [7:0] RST_MONITOR_CONFIGURATION = 8'h60;
    localparam logic [7:0] RST_SUPPLY_THERMAL_STATUS = 8'h00;
    localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;
    // Writable bits of each control register; reserved bits stay zero.
    localparam logic [7:0] WMASK_SUPPLY_OUTPUT_CONTROL = 8'h7F;
    localparam logic [7:0] WMASK_MONITOR_CONFIGURATION = 8'h7E;
    localparam logic [7:0] WMASK_EVENT = 8'h7F;
    // Supply output control fields.
    localparam int CTL_LDO_EN_BIT = 6;
    localparam int CTL_AUX_EN_BIT = 5;
    localparam int CTL_CLK_EN_BIT = 4;
    localparam int CTL_TX_PIN_EN_BIT = 3;
    localparam int CTL_TRIM_MSB = 2;
    localparam int CTL_TRIM_LSB = 0;
    // Monitor configuration fields.
    localparam int CFG_LDO_MASK_BIT = 6;
    localparam int CFG_CONV_MASK_BIT = 5;
    localparam int CFG_FILT_MASK_BIT = 4;
    localparam int CFG_PROBE_MSB = 3;
    localparam int CFG_PROBE_LSB = 1;
    // Status fields.
    localparam int STS_LDO_OK_BIT = 6;
    localparam int STS_CONV_OK_BIT = 5;
    localparam int STS_BUS_OK_BIT = 4;
    localparam int STS_FILT_OK_BIT = 3;
    localparam int STS_XTAL_BIT = 2;
    localparam int STS_THERMAL_WARN_BIT = 1;
    localparam int STS_PAST_SHUTDOWN_BIT = 0;
    // Number of monitored status inputs.
    localparam int STS_WIDTH = 7;
    localparam int TRIM_WIDTH = 3;
    localparam int PROBE_WIDTH = 3;
    // Probe select codes.
    localparam logic [2:0] PROBE_OFF = 3'h0;
    localparam logic [2:0] PROBE_BUS_INPUT_RAIL = 3'h1;
    localparam logic [2:0] PROBE_FILTERED_SUPPLY = 3'h2;
    localparam logic [2:0] PROBE_LDO_RAIL = 3'h3;
    localparam logic [2:0] PROBE_CONVERTER_RAIL = 3'h4;
    localparam logic [2:0] PROBE_ANALOG_CORE_RAIL = 3'h5;
    localparam logic [2:0] PROBE_BUS_CURRENT = 3'h6;
    localparam logic [2:0] PROBE_TEMPERATURE = 3'h7;
endpackage : smrb_pkg

// [hw/smrb_sync.sv]
// Two-stage synchroniser for a vector of independent level inputs.
`timescale 1ns/10ps
`default_nettype none
module smrb_sync #(
    parameter int WIDTH = 7
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // One pair of flops per bit; the first stage feeds only the second.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            logic stable_r;
            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= async_in[gi];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[gi] = stable_r;
        end
    endgenerate
endmodule : smrb_sync
`default_nettype wire

// [hw/smrb_top.sv]
// Supply monitor register bank: control, monitor setup, status and events.
//
// Functional notes
// - Control bit 6 enables LDO, reset one.
// - Control bit 5 enables aux converter, reset one.
// - Control bit 4 enables clock output, reset one.
// - Control bit 3 drives activity pin, else tristate.
// - Control bits 2..0 trim LDO limit, reset 100.
// - Control bit 7 reserved, no function.
// - Config bits 6..4 mask monitors from warning.
// - Config bits 3..1 select analog probe source.
// - Config bits 0 and 7 reserved.
// - Status bit 6 shows LDO rail ok.
// - Status bit 5 shows converter rail ok.
// - Status bit 4 shows bus voltage ok.
// - Status bit 3 shows filtered supply ok.
// - Status bit 2 shows crystal running.
// - Status bit 1 shows thermal warning.
// - Status bit 0 shows past overheat shutdown.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module smrb_top (
    input wire logic SYS_CLK_IN,
    input wire logic SRST_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    input wire logic LDO_OK_IN,
    input wire logic CONVERTER_OUTPUT_OK_IN,
    input wire logic BUS_SUPPLY_OK_IN,
    input wire logic FILTERED_SUPPLY_OK_IN,
    input wire logic XTAL_RUNNING_IN,
    input wire logic THERMAL_WARNING_IN,
    input wire logic PAST_OVERHEAT_SHUTDOWN_IN,
    input wire logic TX_ACTIVITY_IN,
    output logic LDO_REGULATOR_ENABLE_OUT,
    output logic AUX_CONVERTER_ENABLE_OUT,
    output logic CLOCK_OUT_ENABLE_OUT,
    output logic [2:0] LDO_CURRENT_LIMIT_TRIM_OUT,
    output logic [2:0] ANALOG_PROBE_SELECT_OUT,
    output logic TX_ACTIVITY_PIN_OUT,
    output logic TX_ACTIVITY_PIN_OE_N_OUT,
    output logic POWER_FAIL_WARNING_OUT,
    output logic IRQ_OUT
);
    logic [7:0] ctrl_r;
    logic [7:0] cfg_r;
    logic [7:0] status_r;
    logic [7:0] event_r;
    logic [7:0] event_nxt;
    logic [7:0] irq_mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [smrb_pkg::STS_WIDTH-1:0] mon_async;
    logic [smrb_pkg::STS_WIDTH-1:0] mon_sync;
    logic [smrb_pkg::STS_WIDTH-1:0] mon_prev_r;
    logic warn_r;
    logic warn_nxt;
    logic tx_pin_r;
    logic wr_ctrl;
    logic wr_cfg;
    logic wr_mask;
    logic rd_event;

    // Monitor inputs come from the analog domain, so they are synchronised.
    assign mon_async = {LDO_OK_IN, CONVERTER_OUTPUT_OK_IN, BUS_SUPPLY_OK_IN,
                        FILTERED_SUPPLY_OK_IN, XTAL_RUNNING_IN,
                        THERMAL_WARNING_IN, PAST_OVERHEAT_SHUTDOWN_IN};

    smrb_sync #(
        .WIDTH(smrb_pkg::STS_WIDTH)
    ) u_mon_sync (
        .clk_in(SYS_CLK_IN),
        .srst_in(SRST_IN),
        .async_in(mon_async),
        .sync_out(mon_sync)
    );

    // Address decode; the status address has no write path at all.
    assign wr_ctrl = WR_IN && (ADDR_IN == smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL);
    assign wr_cfg = WR_IN && (ADDR_IN == smrb_pkg::ADDR_MONITOR_CONFIGURATION);
    assign wr_mask = WR_IN && (ADDR_IN == smrb_pkg::ADDR_EVENT_MASK);
    assign rd_event = RD_IN && (ADDR_IN == smrb_pkg::ADDR_EVENT_STATUS);

    // Supply output control register; bit 7 is held at zero.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            ctrl_r <= smrb_pkg::RST_SUPPLY_OUTPUT_CONTROL;
        end else if (wr_ctrl) begin
            // Mask keeps the reserved position dead.
            ctrl_r <= WDATA_IN & smrb_pkg::WMASK_SUPPLY_OUTPUT_CONTROL;
        end
    end

    // Monitor configuration register; bits 7 and 0 are held at zero.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            cfg_r <= smrb_pkg::RST_MONITOR_CONFIGURATION;
        end else if (wr_cfg) begin
            cfg_r <= WDATA_IN & smrb_pkg::WMASK_MONITOR_CONFIGURATION;
        end
    end

    // Status image of the synchronised monitors; bit 7 reads zero.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            status_r <= smrb_pkg::RST_SUPPLY_THERMAL_STATUS;
        end else begin
            status_r <= {1'b0, mon_sync};
        end
    end

    // Previous monitor image, used to spot any change of a status bit.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            mon_prev_r <= '0;
        end else begin
            mon_prev_r <= mon_sync;
        end
    end

    // Sticky events on every status change; a new event beats the read clear.
    always_comb begin
        event_nxt = event_r;
        if (rd_event) begin
            event_nxt = 8'h00;
        end
        event_nxt = event_nxt | {1'b0, mon_sync ^ mon_prev_r};
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            event_r <= smrb_pkg::RST_EVENT_STATUS;
        end else begin
            event_r <= event_nxt;
        end
    end

    // Interrupt mask, same layout as the event register, 1 passes an event.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            irq_mask_r <= smrb_pkg::RST_EVENT_MASK;
        end else if (wr_mask) begin
            irq_mask_r <= WDATA_IN & smrb_pkg::WMASK_EVENT;
        end
    end

    // Level interrupt; combinational so it drops as soon as the read clears.
    assign IRQ_OUT = |(event_r & irq_mask_r);

    // Power-fail warning: the bus monitor has no mask and always counts.
    always_comb begin
        warn_nxt = 1'b0;
        if (!mon_sync[smrb_pkg::STS_LDO_OK_BIT]
            && !cfg_r[smrb_pkg::CFG_LDO_MASK_BIT]) begin
            warn_nxt = 1'b1;
        end
        if (!mon_sync[smrb_pkg::STS_CONV_OK_BIT]
            && !cfg_r[smrb_pkg::CFG_CONV_MASK_BIT]) begin
            warn_nxt = 1'b1;
        end
        if (!mon_sync[smrb_pkg::STS_FILT_OK_BIT]
            && !cfg_r[smrb_pkg::CFG_FILT_MASK_BIT]) begin
            warn_nxt = 1'b1;
        end
        if (!mon_sync[smrb_pkg::STS_BUS_OK_BIT]) begin
            warn_nxt = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= warn_nxt;
        end
    end

    // Activity pin data is registered so the pad sees no glitches.
    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            tx_pin_r <= 1'b0;
        end else begin
            tx_pin_r <= TX_ACTIVITY_IN;
        end
    end

    // Read mux; unmapped addresses and idle cycles return zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (RD_IN) begin
            case (ADDR_IN)
                smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL: begin
                    rdata_nxt = ctrl_r;
                end
                smrb_pkg::ADDR_MONITOR_CONFIGURATION: begin
                    rdata_nxt = cfg_r;
                end
                smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS: begin
                    rdata_nxt = status_r;
                end
                smrb_pkg::ADDR_EVENT_STATUS: begin
                    rdata_nxt = event_r;
                end
                smrb_pkg::ADDR_EVENT_MASK: begin
                    rdata_nxt = irq_mask_r;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Output fields straight from the register flops.
    assign RDATA_OUT = rdata_r;
    assign LDO_REGULATOR_ENABLE_OUT = ctrl_r[smrb_pkg::CTL_LDO_EN_BIT];
    assign AUX_CONVERTER_ENABLE_OUT = ctrl_r[smrb_pkg::CTL_AUX_EN_BIT];
    assign CLOCK_OUT_ENABLE_OUT = ctrl_r[smrb_pkg::CTL_CLK_EN_BIT];
    assign LDO_CURRENT_LIMIT_TRIM_OUT =
        ctrl_r[smrb_pkg::CTL_TRIM_MSB:smrb_pkg::CTL_TRIM_LSB];
    assign ANALOG_PROBE_SELECT_OUT =
        cfg_r[smrb_pkg::CFG_PROBE_MSB:smrb_pkg::CFG_PROBE_LSB];
    // Pin data is forced low while released, so the pad never floats data.
    assign TX_ACTIVITY_PIN_OUT =
        tx_pin_r & ctrl_r[smrb_pkg::CTL_TX_PIN_EN_BIT];
    assign TX_ACTIVITY_PIN_OE_N_OUT =
        !ctrl_r[smrb_pkg::CTL_TX_PIN_EN_BIT];
    assign POWER_FAIL_WARNING_OUT = warn_r;

    // Checks: a control write shows on the outputs one cycle later.
    sequence s_ctrl_write;
        !SRST_IN && wr_ctrl;
    endsequence

    a_ldo_enable_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        s_ctrl_write |=> LDO_REGULATOR_ENABLE_OUT == $past(WDATA_IN[6]))
        else $error("LDO enable does not follow the control write.");

    a_aux_enable_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        s_ctrl_write |=> AUX_CONVERTER_ENABLE_OUT == $past(WDATA_IN[5]))
        else $error("Converter enable does not follow the control write.");

    a_clock_enable_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        s_ctrl_write |=> CLOCK_OUT_ENABLE_OUT == $past(WDATA_IN[4]))
        else $error("Clock enable does not follow the control write.");

    a_pin_release_state: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (s_ctrl_write ##1 1'b1) |->
            TX_ACTIVITY_PIN_OE_N_OUT == !$past(WDATA_IN[3]))
        else $error("Activity pin enable does not follow the control write.");

    a_trim_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        s_ctrl_write |=> LDO_CURRENT_LIMIT_TRIM_OUT == $past(WDATA_IN[2:0]))
        else $error("Current limit trim does not follow the control write.");

    a_reset_values: assert property (
        @(posedge SYS_CLK_IN)
        $fell(SRST_IN) |-> ctrl_r == smrb_pkg::RST_SUPPLY_OUTPUT_CONTROL
            && cfg_r == smrb_pkg::RST_MONITOR_CONFIGURATION
            && TX_ACTIVITY_PIN_OE_N_OUT)
        else $error("Register reset values are wrong.");

    a_reserved_zero: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !ctrl_r[7] && !cfg_r[7] && !cfg_r[0] && !status_r[7])
        else $error("A reserved bit holds a one.");

    a_mask_write: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        wr_cfg |=> cfg_r[6:1] == $past(WDATA_IN[6:1])
            && ANALOG_PROBE_SELECT_OUT == $past(WDATA_IN[3:1]))
        else $error("Monitor configuration does not follow the write.");

    // Status reflects a steady monitor input after the two sync stages.
    sequence s_ldo_steady_low;
        !LDO_OK_IN [*4];
    endsequence

    a_status_tracks_input: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        s_ldo_steady_low |-> !status_r[6]
            && (POWER_FAIL_WARNING_OUT || cfg_r[6] || $past(cfg_r[6])))
        else $error("LDO failure missing from status or warning.");

    a_status_read: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        RD_IN && ADDR_IN == smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS
            |=> RDATA_OUT == $past(status_r))
        else $error("Status read returned the wrong value.");

    a_bus_warning: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !BUS_SUPPLY_OK_IN [*4] |-> POWER_FAIL_WARNING_OUT)
        else $error("Bus failure does not raise the warning.");

    a_read_data_once: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !RD_IN |=> RDATA_OUT == 8'h00)
        else $error("Read data outside the answer cycle.");

    a_event_set_wins: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        rd_event && (mon_sync != mon_prev_r) |=> event_r != 8'h00)
        else $error("An event was lost under a read clear.");

    // Writes to the status address leave every control field alone.
    a_status_write_ignored: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        WR_IN && ADDR_IN == smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS
            |=> ctrl_r == $past(ctrl_r) && cfg_r == $past(cfg_r))
        else $error("A status write changed a control register.");

    // A released activity pin never carries data.
    a_pin_data_gated: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        TX_ACTIVITY_PIN_OE_N_OUT |-> !TX_ACTIVITY_PIN_OUT)
        else $error("Released activity pin shows data.");

    // A driving pin shows the activity level of the cycle before.
    a_pin_data_follows: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !TX_ACTIVITY_PIN_OE_N_OUT |-> TX_ACTIVITY_PIN_OUT == $past(TX_ACTIVITY_IN))
        else $error("Driving activity pin does not follow the monitor.");

    // With every supply monitor good the warning stays low.
    a_warn_quiet: assert property (
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        $past(&mon_sync[6:3]) |-> !POWER_FAIL_WARNING_OUT)
        else $error("Warning raised with every supply good.");
endmodule : smrb_top
`default_nettype wire

// [sim/testbench.sv]
// Self-checking testbench for the supply monitor register bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] mon = 7'h7F;
    logic tx_act = 1'b0;
    logic [7:0] rdata;
    logic ldo_en, aux_en, clk_en, pin, pin_oe_n, warn, irq;
    logic [2:0] trim, probe;
    int errors = 0;
    int num_checks = 0;

    // Free-running clock at 100 MHz.
    always #5 clk = ~clk;

    smrb_top dut (.SYS_CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .LDO_OK_IN(mon[6]), .CONVERTER_OUTPUT_OK_IN(mon[5]),
        .BUS_SUPPLY_OK_IN(mon[4]), .FILTERED_SUPPLY_OK_IN(mon[3]),
        .XTAL_RUNNING_IN(mon[2]), .THERMAL_WARNING_IN(mon[1]),
        .PAST_OVERHEAT_SHUTDOWN_IN(mon[0]), .TX_ACTIVITY_IN(tx_act),
        .LDO_REGULATOR_ENABLE_OUT(ldo_en), .AUX_CONVERTER_ENABLE_OUT(aux_en),
        .CLOCK_OUT_ENABLE_OUT(clk_en), .LDO_CURRENT_LIMIT_TRIM_OUT(trim),
        .ANALOG_PROBE_SELECT_OUT(probe), .TX_ACTIVITY_PIN_OUT(pin),
        .TX_ACTIVITY_PIN_OE_N_OUT(pin_oe_n), .POWER_FAIL_WARNING_OUT(warn),
        .IRQ_OUT(irq));

    // Compares one value and reports a difference at once.
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe; all outputs but the registered warning have settled when it returns.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // One-cycle read strobe; data are taken in the cycle after it only.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Changes the monitor inputs and lets them pass the synchroniser.
    task automatic set_mon(input logic [6:0] v);
        @(posedge clk);
        mon <= v;
        repeat (5) @(posedge clk);
        #1;
    endtask : set_mon

    // Reset values of control, config and mask registers and control outputs, startup events, unmapped read.
    task automatic test_reset;
        logic [7:0] d;
        chk("ldo enable", {7'h00, ldo_en}, 8'h01);
        chk("aux enable", {7'h00, aux_en}, 8'h01);
        chk("clock enable", {7'h00, clk_en}, 8'h01);
        chk("pin oe_n", {6'h00, pin_oe_n, pin}, 8'h02);
        chk("trim", {5'h00, trim}, 8'h04);
        chk("probe", {5'h00, probe}, 8'h00);
        rd_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, d);
        chk("control reset", d, smrb_pkg::RST_SUPPLY_OUTPUT_CONTROL);
        rd_reg(smrb_pkg::ADDR_MONITOR_CONFIGURATION, d);
        chk("config reset", d, smrb_pkg::RST_MONITOR_CONFIGURATION);
        rd_reg(smrb_pkg::ADDR_EVENT_MASK, d);
        chk("mask reset", d, smrb_pkg::RST_EVENT_MASK);
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        chk("startup events", d, 8'h7F);
        rd_reg(8'h04, d);
        chk("unmapped read", d, 8'h00);
    endtask : test_reset

    // Control fields, reserved bit, every trim code and the shared pin.
    task automatic test_control;
        logic [7:0] d;
        wr_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, 8'hFF);
        rd_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, d);
        chk("control readback", d, 8'h7F);
        chk("pin oe_n driving", {7'h00, pin_oe_n}, 8'h00);
        @(posedge clk);
        tx_act <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("pin follows", {7'h00, pin}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, 8'h08 | 8'(i));
            chk("trim code", {5'h00, trim}, 8'(i));
            chk("enables off", {5'h00, ldo_en, aux_en, clk_en}, 8'h00);
        end
        wr_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, 8'h50);
        chk("ldo and clock", {5'h00, ldo_en, aux_en, clk_en}, 8'h05);
        chk("pin released", {6'h00, pin_oe_n, pin}, 8'h02);
        wr_reg(smrb_pkg::ADDR_SUPPLY_OUTPUT_CONTROL, 8'h20);
        chk("aux only", {5'h00, ldo_en, aux_en, clk_en}, 8'h02);
        @(posedge clk);
        tx_act <= 1'b0;
    endtask : test_control

    // Probe codes, config reserved bits and ignored status writes.
    task automatic test_config;
        logic [7:0] d;
        wr_reg(smrb_pkg::ADDR_MONITOR_CONFIGURATION, 8'hFF);
        rd_reg(smrb_pkg::ADDR_MONITOR_CONFIGURATION, d);
        chk("config readback", d, 8'h7E);
        for (int i = 0; i < 8; i++) begin
            wr_reg(smrb_pkg::ADDR_MONITOR_CONFIGURATION, 8'(i << 1));
            chk("probe code", {5'h00, probe}, 8'(i));
        end
        wr_reg(smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS, 8'h00);
        rd_reg(smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS, d);
        chk("status write ignored", d, 8'h7F);
    endtask : test_config

    // Each monitor alone low, under several masks: status and warning.
    task automatic test_monitors;
        logic [7:0] d;
        logic [7:0] cfg[10] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h70,
                                8'h00, 8'h00, 8'h70, 8'h70, 8'h70};
        logic [6:0] mv[10] = '{7'h3F, 7'h5F, 7'h77, 7'h6F, 7'h77,
                               7'h3F, 7'h5F, 7'h7B, 7'h7D, 7'h7E};
        logic exp_w[10] = '{0, 0, 1, 1, 0, 1, 1, 0, 0, 0};
        for (int i = 0; i < 10; i++) begin
            wr_reg(smrb_pkg::ADDR_MONITOR_CONFIGURATION, cfg[i]);
            set_mon(mv[i]);
            rd_reg(smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS, d);
            chk("status bits", d, {1'b0, mv[i]});
            chk("warning", {7'h00, warn}, {7'h00, exp_w[i]});
            set_mon(7'h7F);
            chk("warning clear", {7'h00, warn}, 8'h00);
        end
        set_mon(7'h03);
        rd_reg(smrb_pkg::ADDR_SUPPLY_THERMAL_STATUS, d);
        chk("thermal bits", d, 8'h03);
        set_mon(7'h7F);
    endtask : test_monitors

    // Event raised, masked and cleared by reading.
    task automatic test_irq;
        logic [7:0] d;
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        wr_reg(smrb_pkg::ADDR_EVENT_MASK, 8'hFF);
        rd_reg(smrb_pkg::ADDR_EVENT_MASK, d);
        chk("mask readback", d, 8'h7F);
        wr_reg(smrb_pkg::ADDR_EVENT_MASK, 8'h10);
        chk("irq idle", {7'h00, irq}, 8'h00);
        set_mon(7'h6F);
        chk("irq raised", {7'h00, irq}, 8'h01);
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        chk("event bits", d, 8'h10);
        chk("irq cleared", {7'h00, irq}, 8'h00);
        wr_reg(smrb_pkg::ADDR_EVENT_MASK, 8'h00);
        set_mon(7'h7F);
        chk("irq masked", {7'h00, irq}, 8'h00);
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        chk("masked event", d, 8'h10);
        // A monitor change that lands in the clearing read still sets.
        @(posedge clk);
        mon <= 7'h6F;
        @(posedge clk);
        #1;
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        chk("events before race", d, 8'h00);
        rd_reg(smrb_pkg::ADDR_EVENT_STATUS, d);
        chk("set beats clear", d, 8'h10);
        set_mon(7'h7F);
    endtask : test_irq

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Cuts a hung run short and counts it as a mismatch.
    initial begin
        #200000;
        errors++;
        complete_run();
    end

    // Main sequence: reset for six cycles, let status settle, run tests.
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        test_reset();
        test_control();
        test_config();
        test_monitors();
        test_irq();
        complete_run();
    end
endmodule : testbench
`default_nettype wire
